// >>> src/pmx_top.sv
// pmx_top: power mode control register and external interrupt pin
// configuration, with idle/stop mode sequencing.
// assumes the core writes/reads registers over a single-cycle sfr port and
// reports instruction completion; resets of every source arrive on arst_n.
`timescale 1ns/1ps
`default_nettype none
module pmx_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic instr_done,
  input wire logic irq_wake,
  input wire logic [7:0] port0_pins,
  input wire logic mcd_enable,
  output logic [7:0] sfr_rdata,
  output logic cpu_halt,
  output logic periph_clk_en,
  output logic osc_int_en,
  output logic irq_block,
  output logic mcd_active,
  output logic idle_mode,
  output logic stop_mode,
  output logic external_interrupt_zero,
  output logic external_interrupt_one,
  output logic [15:0] fetch_vector
);
  pmx_pkg::pmx_mode_type mode_reg, mode_next;
  logic [5:0] software_flags_reg;
  logic [7:0] irq_cfg_reg;
  logic idle_req_reg, stop_req_reg;
  logic [7:0] pins_meta_reg, pins_sync_reg;
  logic irq0_act, irq1_act;

  wire hit_pwr = sfr_addr == pmx_pkg::PWR_CTRL_ADDR;
  wire hit_cfg = sfr_addr == pmx_pkg::IRQ_CFG_ADDR;
  wire wr_pwr = sfr_wr && hit_pwr;
  wire wr_cfg = sfr_wr && hit_cfg;
  wire set_idle = wr_pwr && sfr_wdata[pmx_pkg::IDLE_BIT];
  wire set_stop = wr_pwr && sfr_wdata[pmx_pkg::STOP_BIT];
  wire ext_irq1_polarity = irq_cfg_reg[pmx_pkg::IRQ1_POL_BIT];
  wire ext_irq0_polarity = irq_cfg_reg[pmx_pkg::IRQ0_POL_BIT];
  wire [2:0] ext_irq1_pin_select =
    irq_cfg_reg[pmx_pkg::IRQ1_SEL_HI:pmx_pkg::IRQ1_SEL_LO];
  wire [2:0] ext_irq0_pin_select =
    irq_cfg_reg[pmx_pkg::IRQ0_SEL_HI:pmx_pkg::IRQ0_SEL_LO];
  wire [7:0] pwr_read = {software_flags_reg, 2'b00};
  wire [7:0] rd_mux = hit_pwr ? pwr_read : (hit_cfg ? irq_cfg_reg : 8'h00);
  wire is_run = mode_reg == pmx_pkg::PM_RUN;
  wire is_idle = mode_reg == pmx_pkg::PM_IDLE;
  wire is_stop = mode_reg == pmx_pkg::PM_STOP;

  // pin inputs cross from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_meta_reg <= 8'h00;
      pins_sync_reg <= 8'h00;
    end else begin
      pins_meta_reg <= port0_pins;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  pmx_pin_sel u_sel1 (
    .clk(clk),
    .arst_n(arst_n),
    .pins(pins_sync_reg),
    .sel(ext_irq1_pin_select),
    .polarity(ext_irq1_polarity),
    .active(irq1_act)
  );

  pmx_pin_sel u_sel0 (
    .clk(clk),
    .arst_n(arst_n),
    .pins(pins_sync_reg),
    .sel(ext_irq0_pin_select),
    .polarity(ext_irq0_polarity),
    .active(irq0_act)
  );

  // pending mode requests wait for the writing instruction to finish
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end else begin
      idle_req_reg <= (idle_req_reg || set_idle) && !instr_done;
      stop_req_reg <= (stop_req_reg || set_stop) && !instr_done;
    end
  end

  // stop wins when both bits land in one write: lower power is safer
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      pmx_pkg::PM_RUN: begin
        if (instr_done && (stop_req_reg || set_stop)) begin
          mode_next = pmx_pkg::PM_STOP;
        end else if (instr_done && (idle_req_reg || set_idle)) begin
          mode_next = pmx_pkg::PM_IDLE;
        end
      end
      pmx_pkg::PM_IDLE: begin
        // wake clears the idle bit; the core then takes the interrupt
        // and returns to the instruction after the idle write
        if (irq_wake) begin
          mode_next = pmx_pkg::PM_RUN;
        end
      end
      pmx_pkg::PM_STOP: begin
        // no way out but arst_n, driven by pin, watchdog or clock detector
        mode_next = pmx_pkg::PM_STOP;
      end
      default: mode_next = pmx_pkg::PM_RUN;
    endcase
  end

  // all reset sources, watchdog and clock detector included, come in
  // on arst_n and put the mode back to run from any state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= pmx_pkg::PM_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      software_flags_reg <= pmx_pkg::PWR_CTRL_RESET[pmx_pkg::FLAGS_HI:
                                                    pmx_pkg::FLAGS_LO];
    end else if (wr_pwr) begin
      software_flags_reg <=
        sfr_wdata[pmx_pkg::FLAGS_HI:pmx_pkg::FLAGS_LO];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_cfg_reg <= pmx_pkg::IRQ_CFG_RESET;
    end else if (wr_cfg) begin
      irq_cfg_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // status outputs other than mcd_active and fetch_vector are registered from mode_next, so they change on the same edge as the mode register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_halt <= 1'b0;
      periph_clk_en <= 1'b1;
      osc_int_en <= 1'b1;
      irq_block <= 1'b0;
      mcd_active <= 1'b0;
      idle_mode <= 1'b0;
      stop_mode <= 1'b0;
      fetch_vector <= pmx_pkg::RESET_VECTOR;
    end else begin
      cpu_halt <= !(mode_next == pmx_pkg::PM_RUN);
      // idle leaves peripherals and registers clocked and untouched
      periph_clk_en <= !(mode_next == pmx_pkg::PM_STOP);
      osc_int_en <= !(mode_next == pmx_pkg::PM_STOP);
      irq_block <= mode_next == pmx_pkg::PM_STOP;
      mcd_active <= mcd_enable;
      idle_mode <= mode_next == pmx_pkg::PM_IDLE;
      stop_mode <= mode_next == pmx_pkg::PM_STOP;
      fetch_vector <= pmx_pkg::RESET_VECTOR;
    end
  end

  // requests are masked by the registered stop state, so they drop one cycle after stop is entered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      external_interrupt_zero <= 1'b0;
      external_interrupt_one <= 1'b0;
    end else begin
      external_interrupt_zero <= irq0_act && !is_stop;
      external_interrupt_one <= irq1_act && !is_stop;
    end
  end

  // software keeps the two-byte follower; the block does not check it

  property p_idle_entry;
    @(posedge clk) disable iff (!arst_n)
    (is_run && instr_done && (set_idle || idle_req_reg) && !set_stop &&
      !stop_req_reg) |=> is_idle && cpu_halt && idle_mode;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle not entered after idle write");

  property p_stop_entry;
    @(posedge clk) disable iff (!arst_n)
    (is_run && instr_done && (set_stop || stop_req_reg))
      |=> is_stop ##1 (!osc_int_en && !periph_clk_en);
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop not entered or oscillator still on");

  property p_idle_wake;
    @(posedge clk) disable iff (!arst_n)
    (is_idle && irq_wake) |=> is_run && !cpu_halt && !idle_mode;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("interrupt did not wake from idle");

  property p_stop_sticks;
    @(posedge clk) disable iff (!arst_n)
    is_stop |=> is_stop [*2];
  endproperty
  a_stop_sticks: assert property (p_stop_sticks)
    else $error("stop left without reset");

  property p_idle_periph;
    @(posedge clk) disable iff (!arst_n)
    is_idle |=> periph_clk_en && osc_int_en;
  endproperty
  a_idle_periph: assert property (p_idle_periph)
    else $error("peripheral clock dropped in idle");

  property p_mode_bits_zero;
    @(posedge clk) disable iff (!arst_n)
    (sfr_rd && hit_pwr) |=> sfr_rdata[1:0] == 2'b00;
  endproperty
  a_mode_bits_zero: assert property (p_mode_bits_zero)
    else $error("mode select bits read nonzero");

  property p_flags_back;
    @(posedge clk) disable iff (!arst_n)
    (wr_pwr ##1 (sfr_rd && hit_pwr && !sfr_wr))
      |=> sfr_rdata[7:2] == $past(sfr_wdata[7:2], 2);
  endproperty
  a_flags_back: assert property (p_flags_back)
    else $error("software flags did not read back");

  property p_irq1_route;
    @(posedge clk) disable iff (!arst_n)
    // the pin path needs two clean cycles after reset before it can agree
    (!is_stop && $past(arst_n) && $stable(irq_cfg_reg))
      |=> external_interrupt_one ==
      ($past(irq_cfg_reg[7]) ~^ $past(pins_sync_reg[irq_cfg_reg[6:4]], 2));
  endproperty
  a_irq1_route: assert property (p_irq1_route)
    else $error("interrupt one polarity or pin wrong");

  property p_irq_quiet_stop;
    @(posedge clk) disable iff (!arst_n)
    is_stop |=> !external_interrupt_zero && !external_interrupt_one;
  endproperty
  a_irq_quiet_stop: assert property (p_irq_quiet_stop)
    else $error("interrupt request in stop mode");

  property p_irq0_route;
    @(posedge clk) disable iff (!arst_n)
    (!is_stop && $past(arst_n) && $stable(irq_cfg_reg))
      |=> external_interrupt_zero ==
      ($past(irq_cfg_reg[3]) ~^ $past(pins_sync_reg[irq_cfg_reg[2:0]], 2));
  endproperty
  a_irq0_route: assert property (p_irq0_route)
    else $error("interrupt zero polarity or pin wrong");

  property p_fetch_vector;
    @(posedge clk) disable iff (!arst_n)
    1'b1 |-> fetch_vector == pmx_pkg::RESET_VECTOR;
  endproperty
  a_fetch_vector: assert property (p_fetch_vector)
    else $error("restart address not zero");

  property p_stop_halt;
    @(posedge clk) disable iff (!arst_n)
    is_stop |=> cpu_halt && stop_mode && irq_block && !osc_int_en;
  endproperty
  a_stop_halt: assert property (p_stop_halt)
    else $error("stop outputs not held");

  property p_cfg_store;
    @(posedge clk) disable iff (!arst_n)
    wr_cfg |=> irq_cfg_reg == $past(sfr_wdata);
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("pin configuration not stored");

  property p_flags_store;
    @(posedge clk) disable iff (!arst_n)
    wr_pwr |=> software_flags_reg ==
      $past(sfr_wdata[pmx_pkg::FLAGS_HI:pmx_pkg::FLAGS_LO]);
  endproperty
  a_flags_store: assert property (p_flags_store)
    else $error("software flags not stored");

  property p_idle_regs;
    @(posedge clk) disable iff (!arst_n)
    (is_idle && !wr_pwr) |=> $stable(software_flags_reg);
  endproperty
  a_idle_regs: assert property (p_idle_regs)
    else $error("register changed in idle");

  property p_mcd_copy;
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> mcd_active == $past(mcd_enable);
  endproperty
  a_mcd_copy: assert property (p_mcd_copy)
    else $error("clock detector enable not followed");

  property p_unmapped_read;
    @(posedge clk) disable iff (!arst_n)
    (sfr_rd && !hit_pwr && !hit_cfg) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_stop_no_wake;
    @(posedge clk) disable iff (!arst_n)
    (is_stop && irq_wake) |=> stop_mode && is_stop;
  endproperty
  a_stop_no_wake: assert property (p_stop_no_wake)
    else $error("interrupt woke the block from stop");
endmodule
`default_nettype wire

// >>> src/pmx_pkg.sv
// pmx_pkg: register addresses, field positions, reset values and timing
// constants for the power mode and external interrupt pin block.
// assumes an 8-bit special-function register port driven by the core.
package pmx_pkg;
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] IRQ_CFG_ADDR = 8'hF4;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_CFG_RESET = 8'h01;
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int FLAGS_LO = 2;
  localparam int FLAGS_HI = 7;
  localparam int IRQ1_POL_BIT = 7;
  localparam int IRQ1_SEL_HI = 6;
  localparam int IRQ1_SEL_LO = 4;
  localparam int IRQ0_POL_BIT = 3;
  localparam int IRQ0_SEL_HI = 2;
  localparam int IRQ0_SEL_LO = 0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int CLK_MHZ = 50;
  localparam int MCD_TIMEOUT_US = 100;
  localparam int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
  localparam logic [5:0] FLAGS_ZERO = 6'h00;
  typedef enum logic [2:0] {
    PM_RUN = 3'b001,
    PM_IDLE = 3'b010,
    PM_STOP = 3'b100
  } pmx_mode_type;
endpackage

// >>> src/pmx_pin_sel.sv
// pmx_pin_sel: picks one port 0 pin and applies the polarity bit,
// producing a registered active-high request.
// assumes the pin vector is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_sel (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] pins,
  input wire logic [2:0] sel,
  input wire logic polarity,
  output logic active
);
  wire picked;
  // sensing only reads the pin, never drives it, so routing is untouched
  assign picked = pins[sel];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active <= 1'b0;
    end else begin
      // 0 means active low, so invert; 1 passes the pin straight
      active <= polarity ? picked : ~picked;
    end
  end
endmodule
`default_nettype wire

// >>> sim/pmx_core_model.sv
// pmx_core_model: interrupt logic beside the core, raising the wake level.
// assumes the block's interrupt requests are active high, on clk.
`timescale 1ns/1ps
`default_nettype none
module pmx_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irq_en,
  input wire logic spurious,
  input wire logic ext0,
  input wire logic ext1,
  output logic irq_wake
);
  // spurious lets the bench show that stop ignores a wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_wake <= 1'b0;
    end else begin
      irq_wake <= (irq_en & (ext0 | ext1)) | spurious;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: self-checking bench for pmx_top.
// assumes single-cycle sfr strobes and the interrupt model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] pa = pmx_pkg::PWR_CTRL_ADDR;
  localparam logic [7:0] ca = pmx_pkg::IRQ_CFG_ADDR;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic instr_done = 1'b0;
  logic [7:0] port0_pins = 8'h00;
  logic mcd_enable = 1'b0;
  logic irq_en = 1'b0;
  logic spurious = 1'b0;
  logic irq_wake, cpu_halt, periph_clk_en, osc_int_en, irq_block;
  logic mcd_active, idle_mode, stop_mode, ext0, ext1;
  logic [7:0] sfr_rdata;
  logic [15:0] fetch_vector;
  logic [7:0] rnd = 8'h47;
  int flags_m;
  int cfg_m;
  int errors = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  pmx_top pmx_top_i (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .instr_done(instr_done), .irq_wake(irq_wake), .port0_pins(port0_pins),
    .mcd_enable(mcd_enable), .sfr_rdata(sfr_rdata), .cpu_halt(cpu_halt),
    .periph_clk_en(periph_clk_en), .osc_int_en(osc_int_en),
    .irq_block(irq_block), .mcd_active(mcd_active), .idle_mode(idle_mode),
    .stop_mode(stop_mode), .external_interrupt_zero(ext0),
    .external_interrupt_one(ext1), .fetch_vector(fetch_vector));

  pmx_core_model pmx_core_model_i (.clk(clk), .arst_n(arst_n),
    .irq_en(irq_en), .spurious(spurious), .ext0(ext0), .ext1(ext1),
    .irq_wake(irq_wake));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dn);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    instr_done <= dn;
    @(posedge clk);
    sfr_wr <= 1'b0;
    instr_done <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input int exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1;
    check(sfr_rdata, 16'(exp));
  endtask

  task automatic final_report;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin : watchdog
    repeat (3000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin : main
    int pins_m;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(pa, 0);
    rd(ca, 1);
    rd(8'h55, 0);
    check(fetch_vector, 16'h0000);
    // each pass gives both selects a new pin; the polarity pair repeats every four passes
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      pins_m = int'(rnd);
      cfg_m = ((i & 1) << 7) | ((7 - i) << 4) | ((i & 2) << 2) | i;
      wr(ca, 8'(cfg_m), 1'b0);
      port0_pins <= rnd;
      repeat (5) @(posedge clk);
      #1;
      check(ext1, 16'(((pins_m >> (7 - i)) & 1) ^ (~i & 1)));
      check(ext0, 16'(((pins_m >> i) & 1) ^ (~(i >> 1) & 1)));
      rd(ca, cfg_m);
    end
    rnd = lfsr(rnd);
    flags_m = int'(rnd) & 'hFC;
    wr(ca, 8'h88, 1'b0);
    port0_pins <= 8'h00;
    wr(pa, 8'(flags_m | 1), 1'b0);
    #1;
    check(cpu_halt, 16'h0000);
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    #1;
    check({cpu_halt, idle_mode, periph_clk_en, osc_int_en}, 16'hF);
    @(posedge clk);
    irq_en <= 1'b1;
    mcd_enable <= 1'b1;
    port0_pins <= 8'h01;
    repeat (12) begin
      @(posedge clk);
      if (idle_mode === 1'b0) break;
    end
    #1;
    check({cpu_halt, idle_mode, ext0}, 16'h1);
    @(posedge clk);
    irq_en <= 1'b0;
    rd(pa, flags_m);
    wr(pa, 8'(flags_m | 3), 1'b1);
    #1;
    check({stop_mode, cpu_halt, osc_int_en, periph_clk_en}, 16'hC);
    @(posedge clk);
    spurious <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({stop_mode, irq_block, ext0, mcd_active}, 16'hD);
    @(posedge clk);
    arst_n <= 1'b0;
    spurious <= 1'b0;
    @(posedge clk);
    #1;
    check({stop_mode, cpu_halt, osc_int_en}, 16'h1);
    check(fetch_vector, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    rd(pa, 0);
    rd(ca, 1);
    final_report();
  end
endmodule
`default_nettype wire
